// ### verilog/pic_top.sv
`timescale 1ns/10ps
module pic_top
	import pic_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Interrupt sources
	input  wire logic [pic_pkg::NDIR-1:0] irq_pin,
	input  wire logic                     ser_sync_pin,
	input  wire logic                     ser_data_pin,
	input  wire logic [pic_pkg::NINT-1:0] int_src,
	// To the core
	output logic             int_req
);
	import pic_pkg::*;

	logic [NDIR-1:0] dir_m_r, dir_s_r;
	logic [1:0]      sync_m_r, data_m_r;
	logic [1:0]      ser_s_r;
	logic            ap;
	logic            wr_en_r;
	logic [11:0]     wr_addr_r;
	logic            wr;
	logic            gr;
	logic            mixed_r, sie_r;
	logic [RATIO_W-1:0] ratio_r, div_r;
	logic [3:0]      ctp_r, slot_r;
	logic [7:0]      spv_r;
	logic [7:0]      vec_r [NSRC];
	logic [3:0]      pri_r [NSRC];
	logic [NSRC-1:0] mask_r, pol_r, sense_r, pend_r, isvc_r, prev_r;
	logic [NSER-1:0] ser_lvl_r;
	logic [CNT_W-1:0] base_r [NTMR];
	logic [CNT_W-1:0] cnt_r [NTMR];
	logic [NTMR-1:0] inh_r, tevt;
	logic [NSRC-1:0] act, setp;
	logic [31:0]     rd_data_r;
	logic            int_req_r;
	logic            found, isvc_any;
	logic [4:0]      best_idx, top_idx;
	logic [3:0]      best_pri, top_pri, thresh;
	logic            ack_take, eoi_take;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rd_data_r;
	assign int_req   = int_req_r;

	// Pin synchronisers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dir_m_r  <= '0;
			dir_s_r  <= '0;
			sync_m_r <= '0;
			ser_s_r  <= '0;
		end
		else
		begin
			dir_m_r  <= irq_pin;
			dir_s_r  <= dir_m_r;
			sync_m_r <= {ser_data_pin, ser_sync_pin};
			ser_s_r  <= sync_m_r;
		end
	end
	assign data_m_r = ser_s_r;

	// Bus decode
	assign ap = hsel & htrans[1] & hready;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_en_r   <= 1'b0;
			wr_addr_r <= '0;
		end
		else
		begin
			wr_en_r   <= ap & hwrite;
			wr_addr_r <= haddr[11:0];
		end
	end
	assign wr       = wr_en_r;
	assign gr       = wr && wr_addr_r == GCR_OFS && hwdata[GCR_RST_BIT];
	assign ack_take = ap && !hwrite && haddr[11:0] == ACK_OFS;
	assign eoi_take = wr && wr_addr_r == EOI_OFS;

	function automatic logic vp_hit(input logic [11:0] a);
		vp_hit = a[11:8] == VP_PAGE && a[7:2] < 6'(NSRC);
	endfunction : vp_hit

	function automatic logic tm_hit(input logic [11:0] a);
		tm_hit = a[11:8] == TMR_PAGE && a[7:5] == 3'h0;
	endfunction : tm_hit

	// Global configuration, mode, task priority, spurious vector
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mixed_r <= 1'b0;
			sie_r   <= 1'b0;
			ratio_r <= '0;
			ctp_r   <= CTP_RST;
			spv_r   <= SPV_RST;
		end
		else if (gr)
		begin
			mixed_r <= 1'b0;
			ctp_r   <= CTP_RST;
			spv_r   <= SPV_RST;
		end
		else if (wr)
		begin
			if (wr_addr_r == GCR_OFS)
				mixed_r <= hwdata[GCR_MIXED_BIT];
			if (wr_addr_r == ICR_OFS)
			begin
				sie_r   <= hwdata[ICR_SIE_BIT];
				ratio_r <= hwdata[ICR_RATIO_LSB +: RATIO_W];
			end
			if (wr_addr_r == CTP_OFS)
				ctp_r <= hwdata[3:0];
			if (wr_addr_r == SPV_OFS)
				spv_r <= hwdata[7:0];
		end
	end

	// Vector/priority registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mask_r  <= '1;
			pol_r   <= '0;
			sense_r <= '0;
			for (int i = 0; i < NSRC; i++)
			begin
				vec_r[i] <= '0;
				pri_r[i] <= '0;
			end
		end
		else if (gr)
			mask_r <= '1;
		else if (wr && vp_hit(wr_addr_r))
		begin
			mask_r[wr_addr_r[6:2]]  <= hwdata[VP_MASK_BIT];
			pol_r[wr_addr_r[6:2]]   <= hwdata[VP_POL_BIT];
			sense_r[wr_addr_r[6:2]] <= hwdata[VP_SENSE_BIT];
			pri_r[wr_addr_r[6:2]]   <= hwdata[VP_PRI_LSB +: 4];
			vec_r[wr_addr_r[6:2]]   <= hwdata[7:0];
		end
	end

	// Serial input frame: sync marks slot 0, one slot per ratio tick
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_r     <= '0;
			slot_r    <= '0;
			ser_lvl_r <= '0;
		end
		else if (mixed_r && sie_r)
		begin
			div_r <= (div_r == ratio_r) ? '0 : div_r + 1'b1;
			if (div_r == ratio_r)
			begin
				slot_r <= data_m_r[0] ? '0 : slot_r + 1'b1;
				ser_lvl_r[data_m_r[0] ? 4'h0 : slot_r + 1'b1] <= data_m_r[1];
			end
		end
	end

	// Global timers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			inh_r <= '1;
			for (int t = 0; t < NTMR; t++)
			begin
				base_r[t] <= '0;
				cnt_r[t]  <= '0;
			end
		end
		else
		begin
			for (int t = 0; t < NTMR; t++)
			begin
				if (gr)
					cnt_r[t] <= base_r[t];
				else if (!inh_r[t])
					cnt_r[t] <= (cnt_r[t] == '0) ? base_r[t] : cnt_r[t] - 1'b1;
			end
			if (wr && tm_hit(wr_addr_r) && !wr_addr_r[2])
			begin
				base_r[wr_addr_r[4:3]] <= hwdata[CNT_W-1:0];
				inh_r[wr_addr_r[4:3]]  <= hwdata[TB_INH_BIT];
			end
		end
	end
	always_comb
	begin
		for (int t = 0; t < NTMR; t++)
			tevt[t] = !inh_r[t] && cnt_r[t] == '0;
	end

	// Source levels and pending set terms; one loop per source group keeps indices in range
	always_comb
	begin
		act = '0;
		for (int i = 0; i < NDIR; i++)
			act[i] = (sie_r ? ser_lvl_r[i] : dir_s_r[i]) ~^ pol_r[i];
		for (int i = NDIR; i < NSER; i++)
			act[i] = sie_r & (ser_lvl_r[i] ~^ pol_r[i]);
		for (int t = 0; t < NTMR; t++)
			act[TMR_SRC0 + t] = tevt[t];
		for (int n = 0; n < NINT; n++)
			act[INT_SRC0 + n] = int_src[n];
		for (int i = 0; i < NSRC; i++)
			setp[i] = mixed_r && (sense_r[i] ? act[i] : act[i] & ~prev_r[i]);
	end

	// Selection of deliverable and in-service sources
	always_comb
	begin
		top_pri  = '0;
		top_idx  = '0;
		isvc_any = 1'b0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (isvc_r[i] && (!isvc_any || pri_r[i] > top_pri))
			begin
				isvc_any = 1'b1;
				top_pri  = pri_r[i];
				top_idx  = 5'(i);
			end
		end
		thresh   = (isvc_any && top_pri > ctp_r) ? top_pri : ctp_r;
		best_pri = thresh;
		best_idx = '0;
		found    = 1'b0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pend_r[i] && !mask_r[i] && !isvc_r[i] && pri_r[i] > best_pri)
			begin
				found    = 1'b1;
				best_pri = pri_r[i];
				best_idx = 5'(i);
			end
		end
	end

	// Pending and in-service state; a new event wins over its clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_r <= '0;
			isvc_r <= '0;
			prev_r <= '0;
		end
		else if (gr)
		begin
			pend_r <= '0;
			isvc_r <= '0;
			prev_r <= act;
		end
		else
		begin
			prev_r <= act;
			for (int i = 0; i < NSRC; i++)
			begin
				if (setp[i])
					pend_r[i] <= 1'b1;
				else if (sense_r[i] && !act[i])
					pend_r[i] <= 1'b0;
				else if (ack_take && found && best_idx == 5'(i))
					pend_r[i] <= 1'b0;
				if (ack_take && found && best_idx == 5'(i))
					isvc_r[i] <= 1'b1;
				else if (eoi_take && isvc_any && top_idx == 5'(i))
					isvc_r[i] <= 1'b0;
			end
		end
	end

	// Read data, registered at the address phase
	function automatic logic [31:0] rd_word(input logic [11:0] a);
		rd_word = ZERO32;
		if (a == GCR_OFS)
			rd_word[GCR_MIXED_BIT] = mixed_r;
		else if (a == ICR_OFS)
		begin
			rd_word[ICR_SIE_BIT] = sie_r;
			rd_word[ICR_RATIO_LSB +: RATIO_W] = ratio_r;
		end
		else if (a == CTP_OFS)
			rd_word[3:0] = ctp_r;
		else if (a == SPV_OFS)
			rd_word[7:0] = spv_r;
		else if (a == PEND_OFS)
			rd_word[NSRC-1:0] = pend_r;
		else if (a == ISVC_OFS)
			rd_word[NSRC-1:0] = isvc_r;
		else if (tm_hit(a))
		begin
			rd_word[CNT_W-1:0] = a[2] ? cnt_r[a[4:3]] : base_r[a[4:3]];
			rd_word[TB_INH_BIT] = !a[2] && inh_r[a[4:3]];
		end
		else if (vp_hit(a))
		begin
			rd_word[VP_MASK_BIT]  = mask_r[a[6:2]];
			rd_word[VP_POL_BIT]   = pol_r[a[6:2]];
			rd_word[VP_SENSE_BIT] = sense_r[a[6:2]];
			rd_word[VP_PRI_LSB +: 4] = pri_r[a[6:2]];
			rd_word[7:0] = vec_r[a[6:2]];
		end
	endfunction : rd_word

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_data_r <= '0;
		else if (ack_take)
			rd_data_r <= {24'h00_0000, found ? vec_r[best_idx] : spv_r};
		else if (ap && !hwrite)
			rd_data_r <= rd_word(haddr[11:0]);
	end

	// Output to the core
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			int_req_r <= 1'b0;
		else
			int_req_r <= mixed_r ? found : dir_s_r[0];
	end

	a_reset_masks: assert property (@(posedge hclk) disable iff (!hresetn)
		gr |=> &mask_r) else $error("global reset left a source enabled");
	a_reset_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		gr |=> pend_r == '0 && isvc_r == '0) else $error("global reset left state");
	a_reset_timer: assert property (@(posedge hclk) disable iff (!hresetn)
		gr |=> cnt_r[0] == $past(base_r[0])) else $error("timer not reloaded");
	a_reset_ctp: assert property (@(posedge hclk) disable iff (!hresetn)
		gr |=> ctp_r == CTP_RST ##1 int_req_r == $past(dir_s_r[0]))
		else $error("task priority not at reset value");
	a_reset_spv: assert property (@(posedge hclk) disable iff (!hresetn)
		gr |=> spv_r == SPV_RST) else $error("spurious vector not at reset value");
	a_reset_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		gr |=> !mixed_r) else $error("not in pass-through after reset");
	a_ack_vector: assert property (@(posedge hclk) disable iff (!hresetn)
		ack_take && found && !gr |=> hrdata[7:0] == $past(vec_r[best_idx])
			&& isvc_r[$past(best_idx)])
		else $error("acknowledge vector wrong");
	a_ack_spurious: assert property (@(posedge hclk) disable iff (!hresetn)
		ack_take && !found |=> hrdata == {24'h00_0000, $past(spv_r)})
		else $error("spurious vector not returned");
	a_eoi_retire: assert property (@(posedge hclk) disable iff (!hresetn)
		eoi_take && isvc_any && !gr |=> !isvc_r[$past(top_idx)]) else $error("END_OF_INTERRUPT_ACCESS did not retire");
	a_inhibit_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		inh_r[0] && !gr |=> cnt_r[0] == $past(cnt_r[0])) else $error("inhibited timer moved");
	a_pass_through: assert property (@(posedge hclk) disable iff (!hresetn)
		!mixed_r |=> int_req_r == $past(dir_s_r[0])) else $error("pass-through not forwarded");
	a_deliver_above: assert property (@(posedge hclk) disable iff (!hresetn)
		mixed_r && found |-> pri_r[best_idx] > ctp_r && !mask_r[best_idx])
		else $error("delivery at or below task priority");

	c_ack_real: cover property (@(posedge hclk) disable iff (!hresetn) ack_take && found);
	c_ack_spur: cover property (@(posedge hclk) disable iff (!hresetn) ack_take && !found);
	c_eoi: cover property (@(posedge hclk) disable iff (!hresetn) eoi_take && isvc_any);
	c_timer: cover property (@(posedge hclk) disable iff (!hresetn) |tevt);
endmodule : pic_top

// ### verilog/pic_pkg.sv
package pic_pkg;
	localparam int NSRC = 24;
	localparam int NTMR = 4;
	localparam int NDIR = 5;
	localparam int NSER = 16;
	localparam int TMR_SRC0 = 16;
	localparam int INT_SRC0 = 20;
	localparam int NINT = 4;
	// Register byte offsets within the block
	localparam logic [11:0] GCR_OFS  = 12'h000;
	localparam logic [11:0] ICR_OFS  = 12'h004;
	localparam logic [11:0] CTP_OFS  = 12'h008;
	localparam logic [11:0] SPV_OFS  = 12'h00C;
	localparam logic [11:0] ACK_OFS  = 12'h010;
	localparam logic [11:0] EOI_OFS  = 12'h014;
	localparam logic [11:0] PEND_OFS = 12'h018;
	localparam logic [11:0] ISVC_OFS = 12'h01C;
	localparam logic [3:0]  TMR_PAGE = 4'h1;
	localparam logic [3:0]  VP_PAGE  = 4'h2;
	// Field positions
	localparam int GCR_RST_BIT   = 31;
	localparam int GCR_MIXED_BIT = 29;
	localparam int ICR_SIE_BIT   = 27;
	localparam int ICR_RATIO_LSB = 28;
	localparam int RATIO_W       = 3;
	localparam int VP_MASK_BIT   = 31;
	localparam int VP_POL_BIT    = 23;
	localparam int VP_SENSE_BIT  = 22;
	localparam int VP_PRI_LSB    = 16;
	localparam int TB_INH_BIT    = 31;
	localparam int CNT_W         = 31;
	// Reset values
	localparam logic [3:0]  CTP_RST = 4'hF;
	localparam logic [7:0]  SPV_RST = 8'hFF;
	localparam logic [31:0] ZERO32  = 32'h0000_0000;
endpackage : pic_pkg

// ### testbench/core_model.sv
`timescale 1ns/10ps
module core_model
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Request and core enable
	input  wire logic       int_req,
	input  wire logic       ext_enable,
	// Count of requests taken
	output logic [7:0]      taken
);
	logic req_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req_r <= 1'b0;
			taken <= 8'h00;
		end
		else
		begin
			req_r <= int_req;
			// Blocked while the core enable is clear
			if (int_req && !req_r && ext_enable)
				taken <= taken + 8'h01;
		end
	end
endmodule : core_model

// ### testbench/programmable_interrupt_controller_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module programmable_interrupt_controller_bench;
	import pic_pkg::*;
	logic        hclk, hresetn, hwrite, hreadyout, hresp, int_req, ext_enable;
	logic        ser_sync, ser_data;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, c1;
	logic [4:0]  irq_pin;
	logic [3:0]  int_src;
	logic [7:0]  taken;
	int          err_count, comparisons;

	pic_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.irq_pin(irq_pin), .ser_sync_pin(ser_sync), .ser_data_pin(ser_data),
		.int_src(int_src), .int_req(int_req));
	core_model i_core (.hclk(hclk), .hresetn(hresetn), .int_req(int_req),
		.ext_enable(ext_enable), .taken(taken));

	always #50 hclk = ~hclk;

	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= {20'h0_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0000_0000);
		`CHK(rd & m, e)
		`CHK(hresp, 1'b0)
	endtask : rdc

	// One serial frame, each slot held two cycles to match a ratio of 1
	task automatic send_frame(input logic [15:0] b);
		for (int k = 0; k < NSER; k++)
		begin
			ser_sync <= (k == 0);
			ser_data <= b[k];
			repeat (2) @(posedge hclk);
		end
		ser_sync <= 1'b1;
		ser_data <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask : send_frame

	task automatic t_serial;
		ser_sync <= 1'b1;
		ser_data <= 1'b0;
		wr(GCR_OFS, 32'h2000_0000);
		wr(ICR_OFS, 32'h1800_0000);
		rdc(ICR_OFS, 32'h7800_0000, 32'h1800_0000);
		wr(CTP_OFS, 32'h0000_0000);
		wr(12'h21C, 32'h00C6_0077);
		send_frame(16'h0080);
		wait_req(1'b1);
		`CHK(int_req, 1'b1)
		`CHK(taken, 8'h04)
		rdc(ACK_OFS, 32'h0000_00FF, 32'h0000_0077);
		send_frame(16'h0000);
		rdc(PEND_OFS, 32'h0000_0080, 32'h0000_0000);
		wr(EOI_OFS, 32'h0000_0000);
		rdc(ISVC_OFS, 32'h00FF_FFFF, 32'h0000_0000);
		$display("serial input test done");
	endtask : t_serial

	task automatic wait_req(input logic v);
		int n;
		n = 0;
		while (int_req !== v && n < 20)
		begin
			@(posedge hclk);
			n++;
		end
	endtask : wait_req

	task automatic t_vp;
		logic [31:0] v;
		for (int s = 0; s < NSRC; s++)
		begin
			v = {8'h80, 4'hC, 4'(s), 8'h00, 8'(255 - s)};
			wr(12'(12'h200 + 4 * s), v);
			rdc(12'(12'h200 + 4 * s), 32'h80CF_00FF, v);
		end
		$display("vector/priority test done");
	endtask : t_vp

	task automatic t_pass;
		irq_pin[0] <= 1'b1;
		wait_req(1'b1);
		`CHK(int_req, 1'b1)
		irq_pin[0] <= 1'b0;
		wait_req(1'b0);
		`CHK(int_req, 1'b0)
		$display("pass-through test done");
	endtask : t_pass

	task automatic t_timer;
		wr(12'h100, 32'h8000_0010);
		rdc(12'h100, 32'hFFFF_FFFF, 32'h8000_0010);
		wr(GCR_OFS, 32'h8000_0000);
		rdc(12'h104, 32'hFFFF_FFFF, 32'h0000_0010);
		wr(12'h100, 32'h0000_0010);
		rdc(12'h104, 32'hFFFF_FFE0, 32'h0000_0000);
		c1 = rd;
		rdc(12'h104, 32'hFFFF_FFE0, 32'h0000_0000);
		`CHK(rd !== c1, 1'b1)
		wr(12'h100, 32'h8000_0010);
		rdc(12'h104, 32'hFFFF_FFE0, 32'h0000_0000);
		c1 = rd;
		repeat (6) @(posedge hclk);
		rdc(12'h104, 32'hFFFF_FFFF, c1);
		wr(12'h100, 32'h0000_0010);
		rdc(12'h104, 32'hFFFF_FFE0, 32'h0000_0000);
		`CHK(rd !== c1, 1'b1)
		wr(12'h100, 32'h8000_0010);
		$display("timer test done");
	endtask : t_timer

	task automatic t_deliver;
		wr(GCR_OFS, 32'h2000_0000);
		wr(CTP_OFS, 32'h0000_0000);
		wr(12'h250, 32'h0045_00A5);
		int_src[0] <= 1'b1;
		wait_req(1'b1);
		`CHK(int_req, 1'b1)
		`CHK(taken, 8'h00)
		rdc(PEND_OFS, 32'h0010_0000, 32'h0010_0000);
		rdc(ACK_OFS, 32'h0000_00FF, 32'h0000_00A5);
		int_src[0] <= 1'b0;
		wait_req(1'b0);
		`CHK(int_req, 1'b0)
		rdc(ISVC_OFS, 32'h00FF_FFFF, 32'h0010_0000);
		wr(EOI_OFS, 32'h0000_0000);
		rdc(ISVC_OFS, 32'h00FF_FFFF, 32'h0000_0000);
		ext_enable <= 1'b1;
		$display("delivery test done");
	endtask : t_deliver

	task automatic t_direct;
		wr(ICR_OFS, 32'h7000_0000);
		wr(12'h204, 32'h0087_0042);
		irq_pin[1] <= 1'b1;
		wait_req(1'b1);
		`CHK(int_req, 1'b1)
		irq_pin[1] <= 1'b0;
		rdc(ACK_OFS, 32'h0000_00FF, 32'h0000_0042);
		wait_req(1'b0);
		wr(EOI_OFS, 32'h0000_0000);
		rdc(ISVC_OFS, 32'h00FF_FFFF, 32'h0000_0000);
		`CHK(taken, 8'h01)
		$display("direct input test done");
	endtask : t_direct

	task automatic t_ctp;
		wr(CTP_OFS, 32'h0000_0005);
		wr(SPV_OFS, 32'h0000_005A);
		wr(12'h254, 32'h0045_0033);
		int_src[1] <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK(int_req, 1'b0)
		rdc(ACK_OFS, 32'h0000_00FF, 32'h0000_005A);
		wr(CTP_OFS, 32'h0000_0004);
		wait_req(1'b1);
		`CHK(int_req, 1'b1)
		wr(12'h254, 32'h8045_0033);
		wait_req(1'b0);
		`CHK(int_req, 1'b0)
		wr(12'h254, 32'h0045_0033);
		wait_req(1'b1);
		rdc(ACK_OFS, 32'h0000_00FF, 32'h0000_0033);
		$display("task priority test done");
	endtask : t_ctp

	task automatic t_greset;
		wr(GCR_OFS, 32'h8000_0000);
		rdc(PEND_OFS, 32'h00FF_FFFF, 32'h0000_0000);
		rdc(ISVC_OFS, 32'h00FF_FFFF, 32'h0000_0000);
		rdc(12'h254, 32'h8000_0000, 32'h8000_0000);
		rdc(CTP_OFS, 32'h0000_000F, 32'h0000_000F);
		rdc(SPV_OFS, 32'h0000_00FF, 32'h0000_00FF);
		rdc(GCR_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		`CHK(int_req, 1'b0)
		$display("global reset test done");
	endtask : t_greset

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	initial
	begin
		#2_000_000;
		err_count++;
		complete_run();
	end

	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		irq_pin = 5'h00;
		int_src = 4'h0;
		ext_enable = 1'b0;
		ser_sync = 1'b0;
		ser_data = 1'b0;
		err_count = 0;
		comparisons = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_pass();
		t_vp();
		t_timer();
		t_deliver();
		t_direct();
		t_ctp();
		t_greset();
		t_serial();
		complete_run();
	end
endmodule : programmable_interrupt_controller_bench
